// *** dv/bcca_checker.sv ***
// Checker: port timing and decode properties of the core
`timescale 1ns/1ps
`default_nettype none
module bcca_checker
  import bcca_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic opc_valid,
  input wire logic [7:0] opc,
  input wire logic [3:0] cond_sel,
  input wire logic opc_ready,
  input wire logic [4:0] op_kind,
  input wire logic decode_valid,
  input wire logic cond_true,
  input wire logic result_valid,
  input wire logic [5:0] flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_take; opc_valid && opc_ready; endsequence
  sequence s_adc; s_take ##0 (opc inside {[OPC_ADC_RR:OPC_ADC_IMM]}); endsequence
  property p_dv; s_take |=> decode_valid; endproperty
  a_dv: assert property (p_dv) else $error("no decode pulse");
  property p_nodv; !(opc_valid && opc_ready) |=> !decode_valid; endproperty
  a_nodv: assert property (p_nodv) else $error("decode without take");
  property p_rv4; s_take ##0 (opc == OPC_ADC_RR) |-> ##4 result_valid; endproperty
  a_rv4: assert property (p_rv4) else $error("short add late");
  property p_rv6; s_adc ##0 (opc != OPC_ADC_RR) |-> ##6 result_valid; endproperty
  a_rv6: assert property (p_rv6) else $error("long add late");
  property p_bsy; s_adc |=> !opc_ready [*3]; endproperty
  a_bsy: assert property (p_bsy) else $error("ready during add");
  property p_ctl;
    s_take ##0 (opc[3:0] == COL_CONTROL) |=> op_kind == 5'(OP_THREAD_ADVANCE) + $past(opc[7:4]);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control decode wrong");
  property p_dcl; s_adc |=> !flags[FL_D]; endproperty
  a_dcl: assert property (p_dcl) else $error("decimal flag kept");
  property p_cnd; cond_sel == COND_NEVER |=> !cond_true; endproperty
  a_cnd: assert property (p_cnd) else $error("never code true");
endmodule : bcca_checker
`default_nettype wire

// *** dv/bcca_core_tb.sv ***
// Testbench: decode map, branch conditions and carry-add
`timescale 1ns/1ps
`default_nettype none
module bcca_core_tb
  import bcca_pkg::*;
;
  logic clk, arst_n, opc_valid, opc_ready, decode_valid, jump_taken, cond_true;
  logic result_valid, flags_load_en, req;
  logic [7:0] opc, dst_in, src_in, result, src_out, byte_in;
  logic [3:0] cond_sel, work_reg, branch_condition_field;
  logic [4:0] op_kind, hs;
  logic [5:0] flags, flags_load, ef;
  logic [8:0] sum;
  int fails = 0, cmp_count = 0, cyc = 0;
  logic [5:0] fl [7] = '{6'h00, 6'h3C, 6'h20, 6'h10, 6'h08, 6'h04, 6'h0C};
  logic [7:0] ta [6] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h16};
  logic [7:0] td [6] = '{8'h10, 8'h80, 8'hFF, 8'h0F, 8'h7F, 8'h7F};
  logic [7:0] ts [6] = '{8'h03, 8'h80, 8'h00, 8'h01, 8'h00, 8'h7F};
  logic [5:0] tc = 6'h35;
  bcca_core i_bcca_core(.clk, .arst_n, .opc_valid, .opc, .dst_in, .src_in, .cond_sel,
    .flags_load, .flags_load_en, .opc_ready, .op_kind, .work_reg, .branch_condition_field,
    .decode_valid, .jump_taken, .cond_true, .result, .result_valid, .src_out, .flags);
  bcca_prog_mem i_bcca_prog_mem(.clk, .arst_n, .req, .byte_in, .opc_ready, .opc_valid, .opc);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      stop_test();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Upper bit of the code inverts the base test
  function automatic logic cond_ref(input logic [3:0] k, input logic [5:0] f);
    logic [7:0] t;
    t = {f[5], f[4], f[3], f[2], f[5] | f[4], f[4] | (f[3] ^ f[2]), f[3] ^ f[2], 1'b0};
    return k[3] ^ t[k[2:0]];
  endfunction : cond_ref
  // Request is dropped before the taking edge, so one idle cycle between bytes
  task issue(input logic [7:0] b);
    @(negedge clk);
    req = 1'b1;
    byte_in = b;
    for (int i = 0; i < 20 && !(opc_valid === 1'b1 && opc_ready === 1'b1); i++) @(negedge clk);
    req = 1'b0;
  endtask : issue
  task setf(input logic [5:0] f);
    @(negedge clk);
    flags_load = f;
    flags_load_en = 1'b1;
    @(negedge clk);
    flags_load_en = 1'b0;
  endtask : setf
  initial begin
    {arst_n, req, flags_load_en, byte_in, dst_in, src_in, cond_sel, flags_load} = '0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    for (int n = 0; n < 16; n++) begin
      issue({4'(n), COL_CONTROL});
      @(negedge clk);
      chk(8'(op_kind), 8'(n + 8));
      if (n > 11) chk(8'(flags[FL_C]), 8'(n == 13));
    end
    $display("control map done");
    for (int n = 7; n < 15; n++) begin
      issue({4'(n - 5), 4'(n)});
      @(negedge clk);
      chk(8'(op_kind), 8'(n - 7));
      chk(8'(work_reg), 8'(n - 5));
    end
    $display("column map done");
    foreach (fl[j]) begin
      setf(fl[j]);
      for (int k = 0; k < 16; k++) begin
        cond_sel = 4'(k);
        issue({4'(k), k[0] ? COL_FAR_JUMP : COL_SHORT_JUMP});
        @(negedge clk);
        chk(8'(cond_true), 8'(cond_ref(4'(k), fl[j])));
        chk(8'(jump_taken), 8'(cond_ref(4'(k), fl[j])));
        chk(8'(branch_condition_field), 8'(k));
      end
    end
    $display("conditions done");
    for (int i = 0; i < 6; i++) begin
      setf({tc[i], 5'h02});
      dst_in = td[i];
      src_in = ts[i];
      issue(ta[i]);
      @(negedge clk);
      sum = {1'b0, td[i]} + {1'b0, ts[i]} + 9'(tc[i]);
      hs = {1'b0, td[i][3:0]} + {1'b0, ts[i][3:0]} + 5'(tc[i]);
      ef = {sum[8], sum[7:0] == 8'h00, sum[7],
        td[i][7] == ts[i][7] && sum[7] != td[i][7], 1'b0, hs[4]};
      chk(result, sum[7:0]);
      chk(src_out, ts[i]);
      chk(8'(flags), 8'(ef));
    end
    repeat (8) @(negedge clk);
    $display("carry add done");
    stop_test();
  end
endmodule : bcca_core_tb
bind bcca_core bcca_checker i_bcca_checker(.clk, .arst_n, .opc_valid, .opc, .cond_sel,
  .opc_ready, .op_kind, .decode_valid, .cond_true, .result_valid, .flags);
`default_nettype wire

// *** dv/bcca_prog_mem.sv ***
// Program memory model: offers one opcode byte per request
`timescale 1ns/1ps
`default_nettype none
module bcca_prog_mem (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req,
  input wire logic [7:0] byte_in,
  input wire logic opc_ready,
  output logic opc_valid,
  output logic [7:0] opc
);
  // Idle bus toggles so a stale byte never passes for a fresh one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opc_valid <= 1'b0;
      opc <= 8'h00;
    end else if (!opc_valid || opc_ready) begin
      opc_valid <= req;
      opc <= req ? byte_in : ~opc;
    end
  end
endmodule : bcca_prog_mem
`default_nettype wire

// *** verilog/bcca_core.sv ***
// Decode of the implied-register map, branch condition test and carry-add execution
`timescale 1ns/1ps
`default_nettype none

// Operation
// - A 4-bit branch condition field gates each conditional jump; 0000 never and 1000 always.
// - Codes 0111/1111 test carry set/clear and 0110/1110 zero set/clear, shared by aliases.
// - Codes 1101/0101 test sign clear/set and 0100/1100 overflow set/clear.
// - Code 1001 holds when sign xor overflow is 0 and code 0001 when it is 1.
// - Code 1011 holds when carry and zero are both clear and 0011 when either is set.
// - Unsigned at-least shares 1111 (carry clear) and unsigned below shares 0111 (carry set).
// - Columns 8 to E use the upper nibble as working register and decode the seven ops.
// - Column F decodes the sixteen one-byte control operations by upper nibble.
// - Carry-add writes dst plus src plus carry into dst and leaves src untouched.
// - Carry-add sets carry on a carry out of bit 7 and clears it otherwise.
// - Carry-add sets zero on a zero result and sign on a negative result.
// - Carry-add sets overflow when like-signed operands give an opposite-signed result.
// - Carry-add clears decimal-adjust and sets half-carry on a carry out of bit 3.
module bcca_core
  import bcca_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic opc_valid,
  input wire logic [7:0] opc,
  input wire logic [7:0] dst_in,
  input wire logic [7:0] src_in,
  input wire logic [3:0] cond_sel,
  input wire logic [5:0] flags_load,
  input wire logic flags_load_en,
  output logic opc_ready,
  output logic [4:0] op_kind,
  output logic [3:0] work_reg,
  output logic [3:0] branch_condition_field,
  output logic decode_valid,
  output logic jump_taken,
  output logic cond_true,
  output logic [7:0] result,
  output logic result_valid,
  output logic [7:0] src_out,
  output logic [5:0] flags
);

  // Every register of the block in one record
  typedef struct packed {
    bcca_state_t st;
    logic [2:0] cnt;
    logic [4:0] op;
    logic [3:0] wreg;
    logic [3:0] bcf;
    logic dvalid;
    logic jump;
    logic ctrue;
    logic [7:0] res;
    logic [7:0] src;
    logic rvalid;
    logic [5:0] fl;
  } bcca_regs_t;

  bcca_regs_t q, d;

  // Shared by the jump columns and the free-running condition port
  function automatic logic cond_eval(input logic [3:0] code, input logic [5:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    logic r;
    c = f[FL_C];
    z = f[FL_Z];
    s = f[FL_S];
    v = f[FL_V];
    // Table form keeps each code traceable to its own test
    unique case (code)
      COND_NEVER: r = 1'b0;
      COND_ALWAYS: r = 1'b1;
      COND_CARRY_SET: r = c;
      COND_CARRY_CLEAR: r = ~c;
      COND_ZERO_SET: r = z;
      COND_ZERO_CLEAR: r = ~z;
      COND_SIGN_CLEAR: r = ~s;
      COND_SIGN_SET: r = s;
      COND_SIGNED_WRAP_SET: r = v;
      COND_SIGNED_WRAP_CLEAR: r = ~v;
      COND_SIGNED_AT_LEAST: r = ~(s ^ v);
      COND_SIGNED_BELOW: r = s ^ v;
      COND_SIGNED_ABOVE: r = ~(z | (s ^ v));
      COND_SIGNED_AT_MOST: r = z | (s ^ v);
      COND_UNSIGNED_ABOVE: r = ~c & ~z;
      COND_UNSIGNED_AT_MOST: r = c | z;
    endcase
    return r;
  endfunction : cond_eval

  // Flag image after a carry-add, every flag rewritten
  function automatic logic [5:0] add_flags(input logic [7:0] a, input logic [7:0] b,
    input logic cin);
    logic [8:0] s9;
    logic [4:0] s5;
    logic [5:0] f;
    s9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    s5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    f[FL_C] = s9[8];
    f[FL_Z] = (s9[7:0] == 8'h00);
    f[FL_S] = s9[7];
    // Overflow only when like-signed operands change sign
    f[FL_V] = (a[7] == b[7]) && (s9[7] != a[7]);
    f[FL_D] = 1'b0;
    f[FL_H] = s5[4];
    return f;
  endfunction : add_flags

  // Carry-add datapath
  logic [8:0] sum9;
  logic is_adc;
  logic [7:0] res8;
  logic [5:0] fl_now;

  // Combinational so the next byte can follow the add's last cycle
  assign opc_ready = (q.st == ST_IDLE);

  always_comb begin
    d = q;
    d.dvalid = 1'b0;
    d.rvalid = 1'b0;
    // A load counts before the opcode's own flag effect
    fl_now = flags_load_en ? flags_load : q.fl;
    d.fl = fl_now;
    d.ctrue = cond_eval(cond_sel, fl_now);

    // Add row sits in columns 2 to 6, clear of the implied map
    is_adc = (opc >= OPC_ADC_RR) && (opc <= OPC_ADC_IMM);
    sum9 = {1'b0, dst_in} + {1'b0, src_in} + {8'h00, fl_now[FL_C]};
    res8 = sum9[7:0];

    unique case (q.st)
      ST_IDLE: begin
        if (opc_valid) begin
          d.dvalid = 1'b1;
          // Non-jump opcodes leave the jump flag low
          d.jump = 1'b0;
          d.wreg = opc[7:4];
          d.bcf = opc[7:4];
          d.op = OP_NONE;
          if (is_adc) begin
            d.op = OP_CARRY_ADD;
            d.res = res8;
            d.src = src_in;
            d.fl = add_flags(dst_in, src_in, fl_now[FL_C]);
            // The take edge already counts as the first cycle
            d.cnt = (opc == OPC_ADC_RR) ? CYC_SHORT - 3'h1 : CYC_LONG - 3'h1;
            d.st = ST_BUSY;
          end else begin
            unique case (opc[3:0])
              COL_MOVE_R_FROM_REG: d.op = OP_MOVE_R_FROM_REG;
              COL_MOVE_REG_FROM_R: d.op = OP_MOVE_REG_FROM_R;
              COL_COUNT_DOWN: d.op = OP_COUNT_DOWN;
              COL_SHORT_JUMP: begin
                d.op = OP_SHORT_JUMP;
                d.jump = cond_eval(opc[7:4], fl_now);
              end
              COL_MOVE_IMM: d.op = OP_MOVE_IMM;
              COL_FAR_JUMP: begin
                d.op = OP_FAR_JUMP;
                d.jump = cond_eval(opc[7:4], fl_now);
              end
              COL_BUMP: d.op = OP_BUMP;
              COL_CONTROL: begin
                // Control ops enumerate in upper-nibble order
                d.op = 5'(OP_THREAD_ADVANCE) + {1'b0, opc[7:4]};
                // Carry ops act on the flags already loaded this cycle
                unique case (opc[7:4])
                  4'hC: d.fl[FL_C] = 1'b0;
                  4'hD: d.fl[FL_C] = 1'b1;
                  4'hE: d.fl[FL_C] = ~fl_now[FL_C];
                  default: ;
                endcase
              end
              // Columns 0 to 7 outside the add row decode as none
              default: d.op = OP_NONE;
            endcase
          end
        end
      end
      ST_BUSY: begin
        // Result released on the last cycle of the instruction's time
        if (q.cnt == 3'h1) begin
          d.rvalid = 1'b1;
          d.st = ST_IDLE;
        end
        d.cnt = q.cnt - 3'h1;
      end
      default: d.st = ST_IDLE;
    endcase
  end

  // One register stage for the whole record
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{st: ST_IDLE, cnt: 3'h0, op: 5'h00, wreg: 4'h0,
             bcf: 4'h0, dvalid: 1'b0,
             jump: 1'b0, ctrue: 1'b0, res: 8'h00, src: 8'h00, rvalid: 1'b0,
             fl: FLAGS_RESET};
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the record, no logic after the flops
  assign op_kind = q.op;
  assign work_reg = q.wreg;
  assign branch_condition_field = q.bcf;
  assign decode_valid = q.dvalid;
  assign jump_taken = q.jump;
  assign cond_true = q.ctrue;
  assign result = q.res;
  assign result_valid = q.rvalid;
  assign src_out = q.src;
  assign flags = q.fl;

endmodule : bcca_core
`default_nettype wire

// *** verilog/bcca_pkg.sv ***
// Package: opcode, condition and timing constants for the decode and carry-add block
package bcca_pkg;
  localparam logic [3:0] COND_NEVER = 4'h0;
  localparam logic [3:0] COND_SIGNED_BELOW = 4'h1;
  localparam logic [3:0] COND_SIGNED_AT_MOST = 4'h2;
  localparam logic [3:0] COND_UNSIGNED_AT_MOST = 4'h3;
  localparam logic [3:0] COND_SIGNED_WRAP_SET = 4'h4;
  localparam logic [3:0] COND_SIGN_SET = 4'h5;
  localparam logic [3:0] COND_ZERO_SET = 4'h6;
  localparam logic [3:0] COND_CARRY_SET = 4'h7;
  localparam logic [3:0] COND_ALWAYS = 4'h8;
  localparam logic [3:0] COND_SIGNED_AT_LEAST = 4'h9;
  localparam logic [3:0] COND_SIGNED_ABOVE = 4'hA;
  localparam logic [3:0] COND_UNSIGNED_ABOVE = 4'hB;
  localparam logic [3:0] COND_SIGNED_WRAP_CLEAR = 4'hC;
  localparam logic [3:0] COND_SIGN_CLEAR = 4'hD;
  localparam logic [3:0] COND_ZERO_CLEAR = 4'hE;
  localparam logic [3:0] COND_CARRY_CLEAR = 4'hF;
  // Column (low nibble) codes of the register-implied map
  localparam logic [3:0] COL_MOVE_R_FROM_REG = 4'h8;
  localparam logic [3:0] COL_MOVE_REG_FROM_R = 4'h9;
  localparam logic [3:0] COL_COUNT_DOWN = 4'hA;
  localparam logic [3:0] COL_SHORT_JUMP = 4'hB;
  localparam logic [3:0] COL_MOVE_IMM = 4'hC;
  localparam logic [3:0] COL_FAR_JUMP = 4'hD;
  localparam logic [3:0] COL_BUMP = 4'hE;
  localparam logic [3:0] COL_CONTROL = 4'hF;
  // Carry-add opcodes
  localparam logic [7:0] OPC_ADC_RR = 8'h12;
  localparam logic [7:0] OPC_ADC_RIR = 8'h13;
  localparam logic [7:0] OPC_ADC_REG = 8'h14;
  localparam logic [7:0] OPC_ADC_IREG = 8'h15;
  localparam logic [7:0] OPC_ADC_IMM = 8'h16;
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG = 3'h6;
  // Flag vector bit positions {c,z,s,v,d,h}
  localparam int FL_C = 5;
  localparam int FL_Z = 4;
  localparam int FL_S = 3;
  localparam int FL_V = 2;
  localparam int FL_D = 1;
  localparam int FL_H = 0;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_MOVE_R_FROM_REG, OP_MOVE_REG_FROM_R, OP_COUNT_DOWN,
    OP_SHORT_JUMP, OP_MOVE_IMM, OP_FAR_JUMP, OP_BUMP,
    OP_THREAD_ADVANCE, OP_THREAD_ENTRY, OP_THREAD_LEAVE, OP_WAIT_FOR_IRQ,
    OP_SELECT_BANK_ZERO, OP_SELECT_BANK_ONE, OP_DOZE, OP_HALT_ALL,
    OP_IRQ_MASK, OP_IRQ_UNMASK, OP_SUBROUTINE_BACK, OP_IRQ_BACK,
    OP_CARRY_ZERO, OP_CARRY_ONE, OP_CARRY_FLIP, OP_IDLE_CYCLE, OP_CARRY_ADD
  } bcca_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } bcca_state_t;
endpackage : bcca_pkg
